// ### common/pswc_pkg.sv
// package for the port, sleep and wakeup controller
package pswc_pkg;
  // register indices, not byte offsets (the byte address is index times four)
  localparam logic [7:0] PSWC_IDX_P0DIR = 8'hB8;
  localparam logic [7:0] PSWC_IDX_P1DIR = 8'hC1;
  localparam logic [7:0] PSWC_IDX_OSC = 8'hCA;
  localparam logic [7:0] PSWC_IDX_P0DAT = 8'hD0;
  localparam logic [7:0] PSWC_IDX_P1DAT = 8'hD1;
  // own registers: bit set/clear, option/ir control and mode status
  localparam logic [7:0] PSWC_IDX_BITOP = 8'hE0;
  localparam logic [7:0] PSWC_IDX_CFG = 8'hE1;
  localparam logic [7:0] PSWC_IDX_STAT = 8'hE2;
  // field positions
  localparam int PSWC_SLEEP_BIT = 3;
  localparam int PSWC_RST_PIN_BIT = 4;
  localparam logic [7:0] PSWC_P0DIR_MASK = 8'hC0;
  localparam logic [7:0] PSWC_P0DAT_MASK = 8'hC0;
  localparam logic [7:0] PSWC_P0IN_MASK = 8'hDF;
  localparam logic [7:0] PSWC_OSC_MASK = 8'h08;
  localparam logic [7:0] PSWC_RESET_VAL = 8'h00;
  // bitop word: [15:8] target index, [2:0] bit, [3] set value
  localparam int PSWC_BITOP_VAL = 3;
  localparam int PSWC_CFG_IR = 0;
  localparam int PSWC_CFG_RSTPIN = 1;
  // timing
  localparam int PSWC_CPU_DIV = 4;
  localparam int PSWC_WAKE_CLOCKS = 4096;
  localparam int PSWC_OSC_START_NS = 1000;
  localparam int PSWC_CLK_NS = 10;
  localparam int PSWC_OSC_START_CYC =
    (PSWC_OSC_START_NS + PSWC_CLK_NS - 1) / PSWC_CLK_NS;
  // ahb codes
  localparam logic [1:0] PSWC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PSWC_HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {PSWC_NORMAL, PSWC_SLEEP, PSWC_START, PSWC_WARM}
    pswc_mode_type;

  // pin bundle carried as one struct
  typedef struct packed {
    logic [7:0] first; // port 0 pins
    logic [7:0] second; // port 1 pins
  } pswc_pins_type;
endpackage

// ### hw/pswc_divider.sv
// instruction-rate divider, one pulse every n running clocks
`timescale 1ns/1ps
module pswc_divider #(
  parameter int DIV = 4
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;

  // count only while running
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
      tick_o <= (cnt_q == LAST);
    end
  end
endmodule // pswc_divider

// ### hw/pswc_top.sv
// port, sleep and wakeup controller with an ahb-lite register slave
// How it works
// - the instruction rate is the system clock divided by four in normal.
// - bit 3 of the oscillator register selects sleep, reset value 0.
// - setting the sleep bit stops the high-speed oscillator.
// - in sleep no instruction runs until a wakeup returns to normal.
// - only port pin changes or reset leave sleep.
// - after wakeup wait for oscillator start, then 4096 clocks.
// - input-mode pins take part in wakeup, except port 0 bit 5 and, with the reset pin option, bit 4.
// - port 0 pins 0 to 4 are input only, pin 4 may be the reset input.
// - with the reset pin option port 0 bit 4 reads as 1.
// - direction bit 0 is input, 1 is output, all reset to 0.
// - port 0 pins 6 and 7 and all port 1 pins are bidirectional.
// - reading a data register returns the pin levels.
// - writing a data register loads output latches, reset to 0.
// - single direction or data bits can be set or cleared alone.
// - infrared output is low when disabled or asleep.
`timescale 1ns/1ps
module pswc_top #(
  parameter int WAKE_CLOCKS = pswc_pkg::PSWC_WAKE_CLOCKS
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // pins
  input wire pswc_pkg::pswc_pins_type pin_in_i,
  output pswc_pkg::pswc_pins_type pin_out_o,
  output pswc_pkg::pswc_pins_type pin_oe_o,
  input wire logic ir_signal_i,
  output logic infrared_output_o,
  // oscillator and core
  output logic osc_enable_o,
  output logic cpu_tick_o,
  output logic cpu_run_o,
  output logic sleep_o
);
  import pswc_pkg::*;

  localparam int WCW = $clog2(WAKE_CLOCKS + 1);
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CLOCKS - 1);
  localparam int SCW = $clog2(PSWC_OSC_START_CYC + 1);
  localparam logic [SCW-1:0] START_LAST = SCW'(PSWC_OSC_START_CYC - 1);

  // register state
  logic [7:0] p0dir_q, p1dir_q, p0lat_q, p1lat_q;
  logic sleep_bit_q, ir_en_q, rst_pin_opt_q;
  logic [15:0] snap_q;
  pswc_mode_type mode_q;
  logic [WCW-1:0] wake_cnt_q;
  logic [SCW-1:0] start_cnt_q;
  // bus address phase capture
  logic wr_q, rd_q;
  logic [7:0] idx_q;
  logic addr_ok_q;
  logic wake;
  logic tick;
  logic [15:0] pins_in, in_mask;
  logic [7:0] first_read, second_read;
  logic wr_now;

  // decode a byte address into the register index
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction

  // read view of port 0: pin levels, bit 5 absent, bit 4 forced by option
  function automatic logic [7:0] first_view(input logic [7:0] lv,
    input logic opt);
    logic [7:0] v;
    v = lv & PSWC_P0IN_MASK;
    if (opt)
      v[PSWC_RST_PIN_BIT] = 1'b1;
    first_view = v;
  endfunction

  assign pins_in = {pin_in_i.second, pin_in_i.first};
  // input mode pins; pin 4 not a port pin when it is the reset input
  assign in_mask = {~p1dir_q,
    ~p0dir_q & PSWC_P0IN_MASK &
    ~(8'(rst_pin_opt_q) << PSWC_RST_PIN_BIT)};
  assign first_read = first_view(pin_in_i.first, rst_pin_opt_q);
  assign second_read = pin_in_i.second;
  assign wr_now = wr_q && addr_ok_q;

  pswc_wake_det u_wake
  (
    .pins_i(pins_in),
    .snap_i(snap_q),
    .is_input_i(in_mask),
    .wake_o(wake)
  );

  pswc_divider #(
    .DIV(PSWC_CPU_DIV)
  ) u_div
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(mode_q == PSWC_NORMAL),
    .tick_o(tick)
  );

  // ahb address phase capture, zero wait states
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= PSWC_RESET_VAL;
      addr_ok_q <= 1'b0;
    end
    else if (hready_i)
    begin
      wr_q <= hsel_i && htrans_i[1] && hwrite_i;
      rd_q <= hsel_i && htrans_i[1] && !hwrite_i;
      idx_q <= idx_of(haddr_i);
      addr_ok_q <= haddr_i[1:0] == 2'b00;
    end
  end

  // bus status outputs: always ready, always okay
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // read data mux, registered for the data phase
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      hrdata_o <= '0;
    else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
    begin
      unique case (idx_of(haddr_i))
        PSWC_IDX_P0DIR: hrdata_o <= {24'h0, p0dir_q};
        PSWC_IDX_P1DIR: hrdata_o <= {24'h0, p1dir_q};
        PSWC_IDX_OSC: hrdata_o <= {24'h0, 4'h0, sleep_bit_q, 3'h0};
        PSWC_IDX_P0DAT: hrdata_o <= {24'h0, first_read};
        PSWC_IDX_P1DAT: hrdata_o <= {24'h0, second_read};
        PSWC_IDX_CFG: hrdata_o <= {30'h0, rst_pin_opt_q, ir_en_q};
        PSWC_IDX_STAT: hrdata_o <= {30'h0, mode_q};
        default: hrdata_o <= '0;
      endcase
    end
  end

  // direction and latch registers, whole-word and single-bit writes
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      p0dir_q <= PSWC_RESET_VAL;
      p1dir_q <= PSWC_RESET_VAL;
      p0lat_q <= PSWC_RESET_VAL;
      p1lat_q <= PSWC_RESET_VAL;
    end
    else if (wr_now)
    begin
      unique case (idx_q)
        PSWC_IDX_P0DIR: p0dir_q <= hwdata_i[7:0] & PSWC_P0DIR_MASK;
        PSWC_IDX_P1DIR: p1dir_q <= hwdata_i[7:0];
        PSWC_IDX_P0DAT: p0lat_q <= hwdata_i[7:0] & PSWC_P0DAT_MASK;
        PSWC_IDX_P1DAT: p1lat_q <= hwdata_i[7:0];
        PSWC_IDX_BITOP:
        begin
          unique case (hwdata_i[15:8])
            PSWC_IDX_P0DIR:
              p0dir_q[hwdata_i[2:0]] <= hwdata_i[PSWC_BITOP_VAL] &
                PSWC_P0DIR_MASK[hwdata_i[2:0]];
            PSWC_IDX_P1DIR:
              p1dir_q[hwdata_i[2:0]] <= hwdata_i[PSWC_BITOP_VAL];
            PSWC_IDX_P0DAT:
              p0lat_q[hwdata_i[2:0]] <= hwdata_i[PSWC_BITOP_VAL] &
                PSWC_P0DAT_MASK[hwdata_i[2:0]];
            PSWC_IDX_P1DAT:
              p1lat_q[hwdata_i[2:0]] <= hwdata_i[PSWC_BITOP_VAL];
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // configuration: infrared enable and reset-pin option
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ir_en_q <= 1'b0;
      rst_pin_opt_q <= 1'b0;
    end
    else if (wr_now && idx_q == PSWC_IDX_CFG)
    begin
      ir_en_q <= hwdata_i[PSWC_CFG_IR];
      rst_pin_opt_q <= hwdata_i[PSWC_CFG_RSTPIN];
    end
  end

  // sleep bit: set by software, cleared when normal mode returns
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      sleep_bit_q <= 1'b0;
    else if (wr_now && idx_q == PSWC_IDX_OSC && mode_q == PSWC_NORMAL)
      sleep_bit_q <= hwdata_i[PSWC_SLEEP_BIT];
    else if (mode_q == PSWC_WARM && wake_cnt_q == WAKE_LAST)
      sleep_bit_q <= 1'b0;
  end

  // mode sequence and wakeup counters
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= PSWC_NORMAL;
      wake_cnt_q <= '0;
      start_cnt_q <= '0;
      snap_q <= '0;
    end
    else
    begin
      unique case (mode_q)
        PSWC_NORMAL:
          if (sleep_bit_q)
          begin
            mode_q <= PSWC_SLEEP;
            snap_q <= pins_in;
          end
        PSWC_SLEEP:
          if (wake)
          begin
            mode_q <= PSWC_START;
            start_cnt_q <= '0;
          end
        PSWC_START:
          if (start_cnt_q == START_LAST)
          begin
            mode_q <= PSWC_WARM;
            wake_cnt_q <= '0;
          end
          else
            start_cnt_q <= start_cnt_q + SCW'(1);
        PSWC_WARM:
          if (wake_cnt_q == WAKE_LAST)
            mode_q <= PSWC_NORMAL;
          else
            wake_cnt_q <= wake_cnt_q + WCW'(1);
      endcase
    end
  end

  // pins, infrared and core control outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
      infrared_output_o <= 1'b0;
      osc_enable_o <= 1'b1;
      cpu_tick_o <= 1'b0;
      cpu_run_o <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      pin_out_o.first <= p0lat_q & p0dir_q;
      pin_out_o.second <= p1lat_q & p1dir_q;
      pin_oe_o.first <= p0dir_q & PSWC_P0DIR_MASK;
      pin_oe_o.second <= p1dir_q;
      infrared_output_o <= ir_signal_i && ir_en_q &&
        mode_q == PSWC_NORMAL;
      osc_enable_o <= !(mode_q == PSWC_SLEEP ||
        (mode_q == PSWC_NORMAL && sleep_bit_q));
      cpu_tick_o <= tick && !sleep_bit_q;
      cpu_run_o <= mode_q == PSWC_NORMAL && !sleep_bit_q;
      sleep_o <= mode_q != PSWC_NORMAL;
    end
  end
endmodule // pswc_top

// ### hw/pswc_wake_det.sv
// pin-change wakeup detector, works without a clock
`timescale 1ns/1ps
module pswc_wake_det
(
  // pins and snapshot
  input wire logic [15:0] pins_i,
  input wire logic [15:0] snap_i,
  input wire logic [15:0] is_input_i,
  // request
  output logic wake_o
);
  // compare live level to the sleep-entry snapshot
  always_comb
  begin
    wake_o = |((pins_i ^ snap_i) & is_input_i);
  end
endmodule // pswc_wake_det

// ### sim/pswc_pin_model.sv
// pin and switch model around the controller's ports
`timescale 1ns/1ps
module pswc_pin_model
(
  // design side
  input wire pswc_pkg::pswc_pins_type pin_out_i,
  input wire pswc_pkg::pswc_pins_type pin_oe_i,
  // switch levels set by the bench
  input wire logic [15:0] sw_i,
  // levels seen at the pins
  output pswc_pkg::pswc_pins_type level_o
);
  import pswc_pkg::*;
  // driven pins follow the design, others the switch; port 0 bit 5 pulled up
  assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & sw_i) |
    16'h2000;
endmodule // pswc_pin_model

// ### sim/pswc_top_checker.sv
// assertions on the controller's ports
`timescale 1ns/1ps
module pswc_top_checker #(
  parameter int WAKE_CLOCKS = 4096
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pins
  input wire pswc_pkg::pswc_pins_type pin_in_i,
  input wire pswc_pkg::pswc_pins_type pin_out_o,
  input wire pswc_pkg::pswc_pins_type pin_oe_o,
  input wire logic ir_signal_i,
  input wire logic infrared_output_o,
  // oscillator and core
  input wire logic osc_enable_o,
  input wire logic cpu_tick_o,
  input wire logic sleep_o
);
  import pswc_pkg::*;
  localparam int WMIN = WAKE_CLOCKS + PSWC_OSC_START_CYC - 4;
  localparam int WMAX = WAKE_CLOCKS + PSWC_OSC_START_CYC + 4;
  logic [15:0] prev_q;
  logic [15:0] wcnt_q;
  logic [3:0] quiet_q;
  // cycles since the pins last moved
  always_ff @(posedge sys_clk_i)
  begin
    prev_q <= pin_in_i;
    if (rst_i || pin_in_i != prev_q)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  end
  // cycles of running oscillator inside a wakeup
  always_ff @(posedge sys_clk_i)
    if (rst_i || !sleep_o || !osc_enable_o)
      wcnt_q <= 16'h0;
    else
      wcnt_q <= wcnt_q + 16'h1;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_gap; cpu_tick_o |=> !cpu_tick_o [*3]; endproperty
  a_gap: assert property (p_gap) else $error("tick too soon");
  property p_per;
    cpu_tick_o ##1 1'b1 [*3] |=> cpu_tick_o || !osc_enable_o;
  endproperty
  a_per: assert property (p_per) else $error("tick missing");
  property p_run; cpu_tick_o |-> !sleep_o; endproperty
  a_run: assert property (p_run) else $error("tick in sleep");
  property p_osc; $rose(sleep_o) |-> ##[0:2] !osc_enable_o; endproperty
  a_osc: assert property (p_osc) else $error("osc kept on");
  property p_pin; $rose(osc_enable_o) |-> quiet_q < 4'h8; endproperty
  a_pin: assert property (p_pin) else $error("wake w/o pin");
  property p_wt; $fell(sleep_o) |-> wcnt_q >= WMIN && wcnt_q <= WMAX;
  endproperty
  a_wt: assert property (p_wt) else $error("wake time");
  property p_ir;
    infrared_output_o |-> $past(ir_signal_i) && !sleep_o;
  endproperty
  a_ir: assert property (p_ir) else $error("ir not low");
  property p_oe; pin_oe_o.first[5:0] == 6'h00; endproperty
  a_oe: assert property (p_oe) else $error("port 0 low pin out");
  property p_out; (pin_out_o & ~pin_oe_o) == 16'h0; endproperty
  a_out: assert property (p_out) else $error("input pin out");
  c_slp: cover property ($rose(sleep_o));
  c_wk: cover property ($fell(sleep_o));
  c_ir: cover property (infrared_output_o);
endmodule // pswc_top_checker

bind pswc_top pswc_top_checker #(.WAKE_CLOCKS(WAKE_CLOCKS)) u_chk (
  .sys_clk_i, .rst_i, .pin_in_i, .pin_out_o, .pin_oe_o, .ir_signal_i,
  .infrared_output_o, .osc_enable_o, .cpu_tick_o, .sleep_o);

// ### sim/test_pswc_top.sv
// self-checking bench for the port, sleep and wakeup controller
`timescale 1ns/1ps
module test_pswc_top;
  import pswc_pkg::*;
  localparam int WK = 16;
  localparam int WT = WK + PSWC_OSC_START_CYC;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic ir_signal_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r, v;
  logic [15:0] sw = 16'hFFFF, dir, lat;
  logic hreadyout_o, hresp_o, infrared_output_o, osc_enable_o;
  logic cpu_tick_o, cpu_run_o, sleep_o;
  pswc_pins_type pin_in_i, pin_out_o, pin_oe_o;
  int err_total = 0, checked = 0, i, n;

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  pswc_top #(.WAKE_CLOCKS(WK)) i_dut (.sys_clk_i, .rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .pin_in_i, .pin_out_o, .pin_oe_o,
    .ir_signal_i, .infrared_output_o, .osc_enable_o, .cpu_tick_o,
    .cpu_run_o, .sleep_o);
  pswc_pin_model i_pins (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .sw_i(sw), .level_o(pin_in_i));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // wait for hready under a bound
  task automatic wait_rdy();
    int k;
    @(posedge sys_clk_i);
    for (k = 0; k < 20 && hreadyout_o !== 1'b1; k++)
      @(posedge sys_clk_i);
    if (hreadyout_o !== 1'b1)
    begin
      err_total++;
      results();
    end
  endtask
  // one ahb-lite single word transfer, read data left in r
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= PSWC_HTRANS_NONSEQ;
    hwrite_i <= w;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    r = hrdata_o;
  endtask
  // expected pin levels: driven pins show the latch, others the switches
  function automatic logic [15:0] lvl();
    return (dir & lat) | (~dir & sw) | 16'h2000;
  endfunction

  // main sequence
  initial
  begin
    v = $urandom(92);
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk({pin_out_o, pin_oe_o}, 32'h0);
    bus(1'b1, 32'h328, 32'hF7);
    bus(1'b0, 32'h328, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 32'h3FC, 32'h0);
    chk(r, 32'h0);
    for (i = 0; i < 12; i++)
    begin
      v = $urandom;
      sw <= 16'($urandom);
      bus(1'b1, 32'h2E0, v);
      bus(1'b1, 32'h304, v >> 8);
      bus(1'b1, 32'h340, v >> 16);
      bus(1'b1, 32'h344, v >> 24);
      dir = {v[7:0] & 8'hC0, v[15:8]};
      lat = {v[23:16] & 8'hC0, v[31:24]};
      v = $urandom;
      bus(1'b1, 32'h380, {16'h0, 8'hC1, 4'h0, v[3:0]});
      bus(1'b1, 32'h380, {16'h0, 8'hD1, 4'h0, v[7:4]});
      dir[v[2:0]] = v[3];
      lat[v[6:4]] = v[7];
      repeat (3) @(posedge sys_clk_i);
      chk({16'h0, pin_oe_o}, {16'h0, dir});
      chk({16'h0, pin_out_o}, {16'h0, dir & lat});
      bus(1'b0, 32'h304, 32'h0);
      chk(r, {24'h0, dir[7:0]});
      bus(1'b0, 32'h2E0, 32'h0);
      chk(r, {24'h0, dir[15:8]});
      v = {16'h0, lvl()};
      bus(1'b0, 32'h344, 32'h0);
      chk(r, {24'h0, v[7:0]});
      bus(1'b0, 32'h340, 32'h0);
      chk(r, {24'h0, v[15:8] & 8'hDF});
    end
    // all inputs, reset-pin option and ir enable
    bus(1'b1, 32'h2E0, 32'h0);
    bus(1'b1, 32'h304, 32'h0);
    bus(1'b1, 32'h384, 32'h3);
    sw <= 16'h0;
    ir_signal_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    bus(1'b0, 32'h340, 32'h0);
    chk(r, 32'h10);
    chk({31'h0, infrared_output_o}, 32'h1);
    bus(1'b1, 32'h384, 32'h1);
    // sleep, then wake by each input pin in turn
    for (i = 0; i < 16; i++)
    begin
      if (i == 13)
        continue;
      bus(1'b1, 32'h328, 32'h8);
      repeat (20) @(posedge sys_clk_i);
      chk({28'h0, osc_enable_o, sleep_o, cpu_run_o, infrared_output_o},
        32'h4);
      bus(1'b0, 32'h328, 32'h0);
      chk(r, 32'h8);
      sw[i] <= ~sw[i];
      // look at sleep_o away from the edge that launches it
      for (n = 0; n < 400 && sleep_o !== 1'b0; n++)
        @(negedge sys_clk_i);
      chk({31'h0, n >= WT && n <= WT + 8}, 32'h1);
      if (n == 400)
        results();
      @(posedge sys_clk_i);
      bus(1'b0, 32'h328, 32'h0);
      chk(r, 32'h0);
    end
    // asleep, then a reset in mid-run must bring normal mode back
    bus(1'b1, 32'h328, 32'h8);
    repeat (20) @(posedge sys_clk_i);
    bus(1'b0, 32'h388, 32'h0);
    chk(r, {30'h0, PSWC_SLEEP});
    chk({30'h0, hresp_o, hreadyout_o}, 32'h1);
    rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk({28'h0, osc_enable_o, sleep_o, cpu_run_o, infrared_output_o},
      32'hA);
    // single-bit ops on port 0 direction: bit 7 sticks, bit 5 absent
    bus(1'b1, 32'h380, {16'h0, 8'hB8, 8'h0F});
    bus(1'b1, 32'h380, {16'h0, 8'hB8, 8'h0D});
    bus(1'b0, 32'h2E0, 32'h0);
    chk(r, 32'h80);
    // count instruction ticks away from the launching edge
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk_i);
      n += int'(cpu_tick_o === 1'b1);
    end
    chk(n, 10);
    results();
  end
endmodule // test_pswc_top
